// ==== bdp_regs.svh ====
// Register offsets, field positions and reset values of the bit pattern source.
`ifndef BDP_REGS_SVH
`define BDP_REGS_SVH
`define BDP_CTRL_OFF 8'h00
`define BDP_STATUS_OFF 8'h04
`define BDP_ULEN_OFF 8'h08
`define BDP_UADDR_OFF 8'h0C
`define BDP_UDATA_OFF 8'h10
`define BDP_EN_BIT 0
`define BDP_SRC_LSB 1
`define BDP_PN_LSB 4
`define BDP_RUN_LSB 7
`define BDP_FIX_LSB 10
`define BDP_BPS_LSB 14
`define BDP_OVR_BIT 8
`define BDP_CTRL_RST 18'h04000
`define BDP_ULEN_RST 16'h0020
`define BDP_PN_SEED 23'h7FFFFF
`endif

// ==== bdp_pkg.sv ====
// Types shared by the bit pattern source.
package bdp_pkg;
  typedef enum logic [2:0] {SRC_PN, SRC_FIXED, SRC_RUN, SRC_USER, SRC_EXT} bdp_src_t;
  typedef enum logic [2:0] {PN_9, PN_11, PN_15, PN_20, PN_23} bdp_pn_t;
endpackage

// ==== bdp_source.sv ====
// Bit FIFO and the selectable data pattern source with its symbol builder.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "bdp_regs.svh"

// Flip-flop FIFO with valid and ready on both sides.
module bdp_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;

  // Full and empty come from the level, so both are exact.
  assign in_ready = (level != (AW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage is written only on an accepted push.
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers wrap at the depth; depth must be a power of two.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop)
        level <= level + 1'b1;
      else if (pop && !push)
        level <= level - 1'b1;
    end
  end
endmodule

// Pattern source top with APB registers.
module bdp_source #(
  parameter int USER_WORDS = 8,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_data,
  input wire logic ext_data_clk,
  input wire logic ext_sym_sync,
  output logic [7:0] sym_data,
  output logic sym_valid,
  input wire logic sym_ready
);
  localparam int UAW = $clog2(USER_WORDS);
  localparam int UB = UAW + 5;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  logic [17:0] ctrl;
  logic [15:0] user_len;
  logic [UAW-1:0] user_addr;
  logic [31:0] user_mem [USER_WORDS];
  logic [UB-1:0] user_ptr;
  logic overrun;
  logic [22:0] lfsr;
  logic [1:0] fix_idx;
  logic [6:0] run_cnt;
  logic ext_clk_q;
  logic [7:0] sym_shift;
  logic [3:0] sym_cnt;
  logic setup;
  logic wr_fire;
  logic hit;
  logic [31:0] rd_mux;
  bdp_pkg::bdp_src_t src;
  bdp_pkg::bdp_pn_t pn_order;
  logic custom_en;
  logic [3:0] bps;
  logic [6:0] run_n;
  logic pn_bit;
  logic pn_fb;
  logic gen_bit;
  logic gen_valid;
  logic gen_sync;
  logic push_fire;
  logic ext_edge;
  logic [1:0] f_out;
  logic f_valid;
  logic f_ready;
  logic f_in_ready;
  logic [LW-1:0] f_level;
  logic [3:0] next_cnt;
  logic [7:0] next_shift;

  // Control fields decoded from the control word.
  assign custom_en = ctrl[`BDP_EN_BIT];
  assign src = bdp_pkg::bdp_src_t'(ctrl[`BDP_SRC_LSB +: 3]);
  assign pn_order = bdp_pkg::bdp_pn_t'(ctrl[`BDP_PN_LSB +: 3]);
  assign bps = (ctrl[`BDP_BPS_LSB +: 4] == 4'h0) ? 4'h1 : ctrl[`BDP_BPS_LSB +: 4];
  assign run_n = 7'h04 << ctrl[`BDP_RUN_LSB +: 3];

  // APB decode; the slave answers with no wait state.
  assign setup = psel && !penable;
  assign wr_fire = psel && penable && pwrite && pready;
  always_comb
  begin
    hit = 1'b1;
    rd_mux = 32'h0;
    case (paddr)
      `BDP_CTRL_OFF: rd_mux = {14'h0, ctrl};
      `BDP_STATUS_OFF: rd_mux = {23'h0, overrun, sym_valid, 2'h0, f_level};
      `BDP_ULEN_OFF: rd_mux = {16'h0, user_len};
      `BDP_UADDR_OFF: rd_mux = {{(32-UAW){1'b0}}, user_addr};
      `BDP_UDATA_OFF: rd_mux = user_mem[user_addr];
      default: hit = 1'b0;
    endcase
  end

  // Read data and error are caught in the setup cycle so they come from flops.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      prdata <= (setup && !pwrite) ? rd_mux : 32'h0;
      pslverr <= setup && !hit;
    end
  end

  // Software-written configuration; a zero file length is held at one.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ctrl <= `BDP_CTRL_RST;
      user_len <= `BDP_ULEN_RST;
      user_addr <= '0;
    end
    else if (wr_fire)
    begin
      case (paddr)
        `BDP_CTRL_OFF: ctrl <= pwdata[17:0];
        `BDP_ULEN_OFF: user_len <= (pwdata[15:0] == 16'h0) ? 16'h1 : pwdata[15:0];
        `BDP_UADDR_OFF: user_addr <= pwdata[UAW-1:0];
        `BDP_UDATA_OFF: user_addr <= user_addr + 1'b1;
        default: ;
      endcase
    end
  end

  // User bit file storage; software may rewrite it at any time.
  always_ff @(posedge sys_clk)
  begin
    if (wr_fire && paddr == `BDP_UDATA_OFF)
    begin
      user_mem[user_addr] <= pwdata;
    end
  end

  // Taps of a maximal-length register for each order.
  always_comb
  begin
    case (pn_order)
      bdp_pkg::PN_9: pn_fb = lfsr[8] ^ lfsr[4];
      bdp_pkg::PN_11: pn_fb = lfsr[10] ^ lfsr[8];
      bdp_pkg::PN_15: pn_fb = lfsr[14] ^ lfsr[13];
      bdp_pkg::PN_20: pn_fb = lfsr[19] ^ lfsr[16];
      bdp_pkg::PN_23: pn_fb = lfsr[22] ^ lfsr[17];
      default: pn_fb = lfsr[8] ^ lfsr[4];
    endcase
  end
  assign pn_bit = pn_fb;

  // Bit of the selected source; only the external one can have gaps.
  assign ext_edge = ext_data_clk && !ext_clk_q;
  always_comb
  begin
    gen_valid = 1'b1;
    gen_sync = 1'b0;
    case (src)
      bdp_pkg::SRC_PN: gen_bit = pn_bit;
      bdp_pkg::SRC_FIXED: gen_bit = ctrl[`BDP_FIX_LSB + 3 - fix_idx];
      bdp_pkg::SRC_RUN: gen_bit = (run_cnt < run_n);
      bdp_pkg::SRC_USER: gen_bit = user_mem[user_ptr[UB-1:5]][user_ptr[4:0]];
      bdp_pkg::SRC_EXT:
      begin
        gen_bit = ext_data;
        gen_valid = ext_edge;
        gen_sync = ext_sym_sync;
      end
      default: gen_bit = pn_bit;
    endcase
  end
  assign push_fire = gen_valid && f_in_ready;

  // Generators advance only when their bit enters the FIFO, so none is skipped.
  always_ff @(posedge sys_clk)
  begin
    if (reset || (wr_fire && paddr == `BDP_CTRL_OFF))
    begin
      lfsr <= `BDP_PN_SEED;
      fix_idx <= 2'h0;
      run_cnt <= 7'h0;
      user_ptr <= '0;
    end
    else if (push_fire)
    begin
      case (src)
        bdp_pkg::SRC_PN: lfsr <= {lfsr[21:0], pn_fb};
        bdp_pkg::SRC_FIXED: fix_idx <= fix_idx + 2'h1;
        bdp_pkg::SRC_RUN: run_cnt <= (run_cnt == ((run_n << 1) - 7'h1)) ? 7'h0 : run_cnt + 7'h1;
        bdp_pkg::SRC_USER:
          user_ptr <= ({{(16-UB){1'b0}}, user_ptr} >= user_len - 16'h1) ? '0 : user_ptr + 1'b1;
        default: ;
      endcase
    end
  end

  // External data clock edge detect and overrun flag; a new overrun beats the clear.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ext_clk_q <= 1'b0;
      overrun <= 1'b0;
    end
    else
    begin
      ext_clk_q <= ext_data_clk;
      if (src == bdp_pkg::SRC_EXT && ext_edge && !f_in_ready)
        overrun <= 1'b1;
      else if (wr_fire && paddr == `BDP_STATUS_OFF && pwdata[`BDP_OVR_BIT])
        overrun <= 1'b0;
    end
  end

  bdp_fifo #(
    .WIDTH(2),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_data({gen_sync, gen_bit}),
    .in_valid(gen_valid),
    .in_ready(f_in_ready),
    .out_data(f_out),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .level(f_level)
  );

  // The builder stalls while disabled or while a symbol waits, so the FIFO back-pressures.
  assign f_ready = custom_en && !(sym_valid && !sym_ready);
  assign next_cnt = f_out[1] ? 4'h1 : sym_cnt + 4'h1;
  // A new symbol starts from zero, so narrow symbols carry no stale upper bits.
  assign next_shift = (f_out[1] || sym_cnt == 4'h0) ? {7'h0, f_out[0]} : {sym_shift[6:0], f_out[0]};

  // Symbol builder packs bits MSB first; a sync bit restarts the symbol.
  always_ff @(posedge sys_clk)
  begin
    if (reset || !custom_en)
    begin
      sym_shift <= 8'h0;
      sym_cnt <= 4'h0;
      sym_data <= 8'h0;
      sym_valid <= 1'b0;
    end
    else
    begin
      if (sym_valid && sym_ready)
        sym_valid <= 1'b0;
      if (f_valid && f_ready)
      begin
        sym_shift <= next_shift;
        sym_cnt <= (next_cnt == bps) ? 4'h0 : next_cnt;
        if (next_cnt == bps)
        begin
          sym_data <= next_shift;
          sym_valid <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== bdp_props.sv ====
// Port checker of the bit pattern source.
`timescale 1ns/1ps
module bdp_props (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] sym_data,
  input wire logic sym_valid,
  input wire logic sym_ready
);
  logic en;
  // Mirror of the custom enable, kept so symbol output can be tied to it.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      en <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == 8'h00)
      en <= pwdata[0];
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  sequence s_setup;
    psel && !penable;
  endsequence
  property p_answer;
    s_setup |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  property p_no_stray;
    pready |-> $past(psel && !penable);
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("answer without setup");
  property p_unmapped;
    s_setup ##0 (paddr > 8'h10) |=> pready && pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_idle_zero;
    !pready |-> prdata == 32'h0 && !pslverr;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("bus outputs not idle");
  property p_hold;
    sym_valid && !sym_ready && !psel |=> sym_valid && $stable(sym_data);
  endproperty
  a_hold: assert property (p_hold) else $error("symbol dropped before taken");
  property p_quiet;
    !en |=> !sym_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("symbol while disabled");
  property p_start;
    $rose(en) |-> ##[1:40] sym_valid;
  endproperty
  a_start: assert property (p_start) else $error("no symbol after enable");
  property p_reset;
    disable iff (1'b0) reset |=> !sym_valid && !pready && prdata == 32'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
endmodule

bind bdp_source bdp_props chk (.sys_clk(sys_clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sym_data(sym_data), .sym_valid(sym_valid),
  .sym_ready(sym_ready));

// ==== bdp_partner.sv ====
// Model of the symbol consumer and of the external serial data source.
`timescale 1ns/1ps
module bdp_partner #(
  parameter logic [7:0] BYTE = 8'h3C
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic slow,
  output logic sym_ready,
  output logic ext_data,
  output logic ext_data_clk,
  output logic ext_sym_sync
);
  logic [4:0] cnt;
  // Phase counter; the data clock runs free and ext_sym_sync marks the first bit of each byte.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      cnt <= 5'h00;
    else
      cnt <= cnt + 5'h01;
  end
  // Data changes on the falling clock half, so the rising edge sees a settled bit.
  assign ext_data_clk = cnt[1];
  assign ext_sym_sync = cnt[4:2] == 3'h0;
  assign ext_data = BYTE[3'h7 - cnt[4:2]];
  // Slow mode stalls the consumer on every other cycle.
  assign sym_ready = !slow || cnt[0];
endmodule

// ==== bdp_source_bench.sv ====
// Testbench of the bit pattern source.
`timescale 1ns/1ps
module bdp_source_bench;
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, err, slow;
  logic sym_valid, sym_ready, ext_data, ext_data_clk, ext_sym_sync;
  logic [7:0] paddr, sym_data, sd, ex;
  logic [31:0] pwdata, prdata, rd;
  int error_cnt, total_checks, ones, md, p;
  bdp_source uut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_data(ext_data), .ext_data_clk(ext_data_clk),
    .ext_sym_sync(ext_sym_sync), .sym_data(sym_data), .sym_valid(sym_valid),
    .sym_ready(sym_ready));
  bdp_partner far (.sys_clk(sys_clk), .reset(reset), .slow(slow), .sym_ready(sym_ready),
    .ext_data(ext_data), .ext_data_clk(ext_data_clk), .ext_sym_sync(ext_sym_sync));
  // Free-running 50 MHz clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // One APB transfer; the leading edge keeps a release and a new setup apart.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only pready or the watchdog ends this wait; the slave decides how long it takes.
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic get_sym();
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (!(sym_valid === 1'b1 && sym_ready === 1'b1) && n < 200);
    sd = sym_data;
    if (sym_valid !== 1'b1 || sym_ready !== 1'b1)
    begin
      error_cnt++;
      $display("unexpected at %0t: no symbol taken", $time);
    end
  endtask
  // Reset leaves 16 PN bits in the FIFO, which every test skips.
  task automatic rst();
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (30) @(posedge sys_clk);
  endtask
  function automatic logic pat(input int m, input int q, input int i);
    if (m == 1)
      return q[3 - i % 4];
    if (m == 2)
      return (i / q) % 2 == 0;
    return q[i % 8];
  endfunction
  task automatic conclude();
    $display("errors %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected run length.
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    conclude();
  end
  // Main sequence.
  initial
  begin
    {reset, psel, penable, pwrite, slow} = 5'b10000;
    paddr = 8'h00;
    pwdata = 32'h0;
    rst();
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h4000);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h20);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h10);
    apb(1'b1, 8'h40, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    // Fixed word, five run lengths and user file, eight bits a symbol.
    for (int t = 0; t < 7; t++)
    begin
      rst();
      slow <= t[0];
      apb(1'b1, 8'h08, 32'h8);
      apb(1'b1, 8'h10, 32'h1);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd, 32'h1);
      md = (t == 0) ? 1 : (t == 6) ? 3 : 2;
      p = (t == 0) ? 10 : (t == 6) ? 1 : 4 << (t - 1);
      apb(1'b1, 8'h00, 32'h20001 | (md << 1) | ((t == 0) ? 32'h2800 : (t - 1) << 7));
      repeat (2) get_sym();
      for (int k = 0; k < 16; k++)
      begin
        get_sym();
        for (int j = 0; j < 8; j++)
          ex[7 - j] = pat(md, p, 8 * k + j);
        chk(32'(sd), 32'(ex));
      end
    end
    // One full period of PN9 and PN11 holds one more one than zeros.
    for (int o = 0; o < 2; o++)
    begin
      rst();
      apb(1'b1, 8'h00, 32'h4001 | (o << 4));
      repeat (16) get_sym();
      ones = 0;
      for (int k = 0; k < (1 << (9 + 2 * o)) - 1; k++)
      begin
        get_sym();
        ones += sd[0];
        chk(32'(sd[7:1]), 32'h0);
      end
      chk(ones, 1 << (8 + 2 * o));
    end
    rst();
    apb(1'b1, 8'h00, 32'h20009);
    repeat (3) get_sym();
    repeat (4)
    begin
      get_sym();
      chk(32'(sd), 32'h3C);
    end
    apb(1'b1, 8'h00, 32'h20008);
    repeat (100) @(posedge sys_clk);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h110);
    // Leave the external source so no new overrun can beat the clear.
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h100);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h10);
    // Fixed word 1011 at four bits a symbol; the stale bits fill four symbols.
    rst();
    apb(1'b1, 8'h00, 32'h12C03);
    repeat (4) get_sym();
    repeat (2)
    begin
      get_sym();
      chk(32'(sd), 32'h0B);
    end
    conclude();
  end
endmodule
